// ---- rtl/vwc_map.svh ----
// Register indices, field positions, reset values and counts of the VBI window bank
`ifndef VWC_MAP_SVH
`define VWC_MAP_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define VWC_IDX_FIRST_EVEN 10'h134
`define VWC_IDX_LAST_EVEN  10'h135
`define VWC_IDX_FIRST_ODD  10'h136
`define VWC_IDX_LAST_ODD   10'h137
`define VWC_IDX_WIN_CTRL   10'h138
`define VWC_IDX_SLICE_LEN  10'h139
`define VWC_IDX_CTRL_LATCH 10'h140
`define VWC_IDX_STATE_RB   10'h141

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define VWC_RST_FIRST_EVEN 12'h110
`define VWC_RST_LAST_EVEN  12'h11B
`define VWC_RST_FIRST_ODD  12'h00A
`define VWC_RST_LAST_ODD   12'h015
`define VWC_RST_WIN_CTRL   12'h000
`define VWC_RST_SLICE_LEN  12'h000
`define VWC_RST_SYNC_MODE  2'h0

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define VWC_WC_ENABLE      0
`define VWC_WC_SLICED      1
`define VWC_WC_SUPPRESS    2
`define VWC_WC_COMMIT      11
`define VWC_CL_SYNC_LO     0
`define VWC_CL_SYNC_HI     1
`define VWC_CL_ACTIVE_VIDEO_FLAG_PROG   2
`define VWC_CL_WIN1_COMMIT 5
`define VWC_CL_WIN2_COMMIT 6
`define VWC_CL_DEC_COMMIT  10
`define VWC_CL_TIM_COMMIT  11
`define VWC_SR_WIN_ENABLE  5
`define VWC_SR_WIN_SLICED  6
`define VWC_SR_WIN_SUPPR   7

// ----------------------------------------------------------------------------
// Counts
// ----------------------------------------------------------------------------
`define VWC_RAW_SAMPLES    11'h474
`define VWC_SLICE_DEFAULT  12'h040

`endif

// ---- rtl/vwc_pkg.sv ----
// Types shared by the VBI window and control latch bank
package vwc_pkg;

  // Register word as seen by software
  typedef logic [11:0] vwc_word_t;

  // Sync timing modes
  typedef enum logic [1:0] {
    VWC_SYNC_OPEN = 2'h0,
    VWC_SYNC_SCAN = 2'h2
  } vwc_sync_e;

endpackage : vwc_pkg

// ---- rtl/vwc_window_latch.sv ----
// VBI window, slicer length and control latch register bank on APB
// Notes on behaviour
// - Even window starts at even first line, 272.
// - Even window ends at even last line, 283.
// - Even lines compared against whole-frame line count.
// - Odd window starts at odd first line, 10.
// - Odd window ends at odd last line, 21.
// - Window acts only while enable bit set.
// - Raw mode passes 1140 samples per line.
// - Sliced mode outputs teletext in payload-length packages.
// - Suppress bit blanks active-video flag in window.
// - Old window settings kept until commit written.
// - Payload length zero means 64 bytes.
// - Sync mode 00 tracks input, 10 free-runs.
// - Active-video length from window or programmed.
// - Window 1/2 commit latches, then self-clears.
// - Decimation count latched on commit, self-clears.
// - Sync mode changes only on timing commit.
// - Read-only state word shows settings in effect.
// - Range-protection format applies inside window only.
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "vwc_map.svh"

module vwc_window_latch
  import vwc_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rstn_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Video timing from the decoder core
  input  wire logic [11:0] frame_line_i,
  input  wire logic        field_odd_i,
  input  wire logic        line_start_i,
  input  wire logic        sample_stb_i,
  input  wire logic        slice_byte_stb_i,
  input  wire logic        window_act_i,
  input  wire logic        field_act_i,
  input  wire logic        range_fmt_i,
  // Window and data path controls
  output logic             vbi_window_o,
  output logic             active_video_flag_o,
  output logic             raw_pass_o,
  output logic             sliced_pass_o,
  output logic             slice_pkg_end_o,
  output logic             range_fmt_o,
  output logic      [11:0] payload_len_o,
  // Timing and latch controls
  output logic             sync_free_run_o,
  output logic             active_video_flag_programmed_o,
  output logic             window1_commit_o,
  output logic             window2_commit_o,
  output logic             decim_commit_o
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------

  // Register index match on a word-aligned byte address
  function automatic logic vwc_hit(input logic [11:0] addr, input logic [9:0] idx);
    return addr == {idx, 2'b00};
  endfunction : vwc_hit

  // Inclusive line range test
  function automatic logic vwc_in_range(input logic [11:0] line, input logic [11:0] first,
                                        input logic [11:0] last);
    return (line >= first) && (line <= last);
  endfunction : vwc_in_range

  // --------------------------------------------------------------------------
  // APB handshake: one wait state, answer registered
  // --------------------------------------------------------------------------
  logic            pready_q;
  logic            pslverr_q;
  logic [31:0]     prdata_q;
  logic            acc_w;
  logic            wr_w;
  logic            mapped_w;
  logic            wr_ok_w;
  vwc_word_t       wdat_w;
  vwc_word_t       rdat_w;

  assign acc_w    = psel_i & penable_i & ~pready_q;
  assign wr_w     = psel_i & penable_i & pready_q & pwrite_i & ~pslverr_q;
  assign wdat_w   = pwdata_i[11:0];
  assign mapped_w = vwc_hit(paddr_i, `VWC_IDX_FIRST_EVEN) | vwc_hit(paddr_i, `VWC_IDX_LAST_EVEN)
                  | vwc_hit(paddr_i, `VWC_IDX_FIRST_ODD)  | vwc_hit(paddr_i, `VWC_IDX_LAST_ODD)
                  | vwc_hit(paddr_i, `VWC_IDX_WIN_CTRL)   | vwc_hit(paddr_i, `VWC_IDX_SLICE_LEN)
                  | vwc_hit(paddr_i, `VWC_IDX_CTRL_LATCH) | vwc_hit(paddr_i, `VWC_IDX_STATE_RB);
  // Writing the state word is refused with an error
  assign wr_ok_w  = mapped_w & ~(pwrite_i & vwc_hit(paddr_i, `VWC_IDX_STATE_RB));

  // Ready, error and read data, all from flops
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= acc_w;
      pslverr_q <= acc_w & ~wr_ok_w;
      prdata_q  <= (acc_w & ~pwrite_i) ? {20'h0_0000, rdat_w} : 32'h0000_0000;
    end
  end

  // --------------------------------------------------------------------------
  // Shadow registers (software side)
  // --------------------------------------------------------------------------
  vwc_word_t sh_first_even_q;
  vwc_word_t sh_last_even_q;
  vwc_word_t sh_first_odd_q;
  vwc_word_t sh_last_odd_q;
  logic [2:0] sh_wctrl_q;
  vwc_word_t sh_slice_len_q;
  logic [1:0] sh_sync_q;
  logic       sh_active_video_flag_q;

  // Written values wait here until their commit
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      sh_first_even_q <= `VWC_RST_FIRST_EVEN;
      sh_last_even_q  <= `VWC_RST_LAST_EVEN;
      sh_first_odd_q  <= `VWC_RST_FIRST_ODD;
      sh_last_odd_q   <= `VWC_RST_LAST_ODD;
      sh_wctrl_q      <= 3'(`VWC_RST_WIN_CTRL);
      sh_slice_len_q  <= `VWC_RST_SLICE_LEN;
      sh_sync_q       <= `VWC_RST_SYNC_MODE;
      sh_active_video_flag_q       <= 1'b0;
    end else if (wr_w) begin
      if (vwc_hit(paddr_i, `VWC_IDX_FIRST_EVEN)) sh_first_even_q <= wdat_w;
      if (vwc_hit(paddr_i, `VWC_IDX_LAST_EVEN))  sh_last_even_q  <= wdat_w;
      if (vwc_hit(paddr_i, `VWC_IDX_FIRST_ODD))  sh_first_odd_q  <= wdat_w;
      if (vwc_hit(paddr_i, `VWC_IDX_LAST_ODD))   sh_last_odd_q   <= wdat_w;
      if (vwc_hit(paddr_i, `VWC_IDX_WIN_CTRL))   sh_wctrl_q      <= wdat_w[2:0];
      if (vwc_hit(paddr_i, `VWC_IDX_SLICE_LEN))  sh_slice_len_q  <= wdat_w;
      if (vwc_hit(paddr_i, `VWC_IDX_CTRL_LATCH))
        {sh_active_video_flag_q, sh_sync_q} <= wdat_w[`VWC_CL_ACTIVE_VIDEO_FLAG_PROG:`VWC_CL_SYNC_LO];
    end
  end

  // --------------------------------------------------------------------------
  // Self-clearing commit bits
  // --------------------------------------------------------------------------
  logic       wc_commit_w;
  logic [3:0] cl_commit_w;
  logic       win_pend_q;
  logic [3:0] cl_pend_q;

  assign wc_commit_w = wr_w & vwc_hit(paddr_i, `VWC_IDX_WIN_CTRL) & wdat_w[`VWC_WC_COMMIT];
  assign cl_commit_w = {4{wr_w & vwc_hit(paddr_i, `VWC_IDX_CTRL_LATCH)}}
                     & {wdat_w[`VWC_CL_TIM_COMMIT], wdat_w[`VWC_CL_DEC_COMMIT],
                        wdat_w[`VWC_CL_WIN2_COMMIT], wdat_w[`VWC_CL_WIN1_COMMIT]};

  // Pending bit is consumed the cycle after it is seen; a new write wins
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      win_pend_q <= 1'b0;
      cl_pend_q  <= 4'h0;
    end else begin
      win_pend_q <= wc_commit_w;
      cl_pend_q  <= cl_commit_w;
    end
  end

  // --------------------------------------------------------------------------
  // Working registers (settings in effect)
  // --------------------------------------------------------------------------
  vwc_word_t wk_first_even_q;
  vwc_word_t wk_last_even_q;
  vwc_word_t wk_first_odd_q;
  vwc_word_t wk_last_odd_q;
  logic      wk_enable_q;
  logic      wk_sliced_q;
  logic      wk_suppress_q;
  vwc_word_t wk_slice_len_q;
  vwc_sync_e wk_sync_q;
  logic      wk_active_video_flag_q;
  logic      free_q;

  // Window table copied only on its commit
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      wk_first_even_q <= `VWC_RST_FIRST_EVEN;
      wk_last_even_q  <= `VWC_RST_LAST_EVEN;
      wk_first_odd_q  <= `VWC_RST_FIRST_ODD;
      wk_last_odd_q   <= `VWC_RST_LAST_ODD;
      {wk_suppress_q, wk_sliced_q, wk_enable_q} <= 3'(`VWC_RST_WIN_CTRL);
      wk_slice_len_q  <= `VWC_RST_SLICE_LEN;
    end else if (win_pend_q) begin
      wk_first_even_q <= sh_first_even_q;
      wk_last_even_q  <= sh_last_even_q;
      wk_first_odd_q  <= sh_first_odd_q;
      wk_last_odd_q   <= sh_last_odd_q;
      {wk_suppress_q, wk_sliced_q, wk_enable_q} <= sh_wctrl_q[`VWC_WC_SUPPRESS:`VWC_WC_ENABLE];
      wk_slice_len_q  <= sh_slice_len_q;
    end
  end

  // Timing mode copied only on the timing commit
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      wk_sync_q <= VWC_SYNC_OPEN;
      wk_active_video_flag_q <= 1'b0;
      free_q    <= 1'b0;
    end else if (cl_pend_q[3]) begin
      wk_sync_q <= vwc_sync_e'(sh_sync_q);
      wk_active_video_flag_q <= sh_active_video_flag_q;
      free_q    <= (vwc_sync_e'(sh_sync_q) == VWC_SYNC_SCAN);
    end
  end

  // --------------------------------------------------------------------------
  // Read mux: window table is write-only and reads zero
  // --------------------------------------------------------------------------
  always_comb begin
    rdat_w = 12'h000;
    if (vwc_hit(paddr_i, `VWC_IDX_CTRL_LATCH)) begin
      rdat_w[`VWC_CL_ACTIVE_VIDEO_FLAG_PROG:`VWC_CL_SYNC_LO]       = {sh_active_video_flag_q, sh_sync_q};
      rdat_w[`VWC_CL_WIN2_COMMIT:`VWC_CL_WIN1_COMMIT] = cl_pend_q[1:0];
      rdat_w[`VWC_CL_TIM_COMMIT:`VWC_CL_DEC_COMMIT]   = cl_pend_q[3:2];
    end else if (vwc_hit(paddr_i, `VWC_IDX_STATE_RB)) begin
      rdat_w[`VWC_CL_ACTIVE_VIDEO_FLAG_PROG:`VWC_CL_SYNC_LO]       = {wk_active_video_flag_q, wk_sync_q};
      rdat_w[`VWC_SR_WIN_SUPPR:`VWC_SR_WIN_ENABLE]    = {wk_suppress_q, wk_sliced_q, wk_enable_q};
    end
  end

  // --------------------------------------------------------------------------
  // Window decision and data path controls
  // --------------------------------------------------------------------------
  logic       in_win_w;
  logic       win_q;
  logic       avf_q;
  logic       range_q;
  logic [10:0] raw_cnt_q;
  logic       raw_q;
  vwc_word_t  pay_len_w;
  vwc_word_t  pay_len_q;
  vwc_word_t  byte_cnt_q;
  logic       sliced_q;
  logic       pkg_end_q;
  logic       pkg_last_w;

  // Even lines use the whole-frame count directly
  assign in_win_w = wk_enable_q & (field_odd_i
                  ? vwc_in_range(frame_line_i, wk_first_odd_q, wk_last_odd_q)
                  : vwc_in_range(frame_line_i, wk_first_even_q, wk_last_even_q));
  assign pay_len_w  = (wk_slice_len_q == 12'h000) ? `VWC_SLICE_DEFAULT : wk_slice_len_q;
  assign pkg_last_w = (byte_cnt_q == pay_len_q - 12'h001);

  // Window flag, active-video flag and range format gate
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      win_q   <= 1'b0;
      avf_q   <= 1'b0;
      range_q <= 1'b0;
    end else begin
      win_q   <= in_win_w;
      avf_q   <= (wk_active_video_flag_q ? field_act_i : window_act_i)
               & ~(in_win_w & wk_suppress_q);
      range_q <= range_fmt_i & in_win_w;
    end
  end

  // Raw sample pass-through, limited per line
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      raw_cnt_q <= 11'h000;
      raw_q     <= 1'b0;
    end else begin
      raw_q <= in_win_w & ~wk_sliced_q & sample_stb_i & (raw_cnt_q < `VWC_RAW_SAMPLES);
      if (line_start_i) begin
        raw_cnt_q <= 11'h000;
      end else if (in_win_w & ~wk_sliced_q & sample_stb_i & (raw_cnt_q < `VWC_RAW_SAMPLES)) begin
        raw_cnt_q <= raw_cnt_q + 11'h001;
      end
    end
  end

  // Sliced byte packaging
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      pay_len_q  <= `VWC_SLICE_DEFAULT;
      byte_cnt_q <= 12'h000;
      sliced_q   <= 1'b0;
      pkg_end_q  <= 1'b0;
    end else begin
      pay_len_q <= pay_len_w;
      sliced_q  <= in_win_w & wk_sliced_q & slice_byte_stb_i;
      pkg_end_q <= in_win_w & wk_sliced_q & slice_byte_stb_i & pkg_last_w;
      if (line_start_i) begin
        byte_cnt_q <= 12'h000;
      end else if (in_win_w & wk_sliced_q & slice_byte_stb_i) begin
        byte_cnt_q <= pkg_last_w ? 12'h000 : byte_cnt_q + 12'h001;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign prdata_o            = prdata_q;
  assign pready_o            = pready_q;
  assign pslverr_o           = pslverr_q;
  assign vbi_window_o        = win_q;
  assign active_video_flag_o = avf_q;
  assign raw_pass_o          = raw_q;
  assign sliced_pass_o       = sliced_q;
  assign slice_pkg_end_o     = pkg_end_q;
  assign range_fmt_o         = range_q;
  assign payload_len_o       = pay_len_q;
  assign sync_free_run_o     = free_q;
  assign active_video_flag_programmed_o   = wk_active_video_flag_q;
  assign window1_commit_o    = cl_pend_q[0];
  assign window2_commit_o    = cl_pend_q[1];
  assign decim_commit_o      = cl_pend_q[2];

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking vwc_cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  AST_WIN_COMMIT: assert property (wc_commit_w
                                   |=> ##1 (wk_first_even_q == $past(sh_first_even_q)))
    else $error("window table not adopted after commit");
  AST_WIN_HOLD: assert property (!win_pend_q |=> $stable(wk_first_odd_q))
    else $error("window table changed without commit");
  AST_SELF_CLEAR: assert property (cl_commit_w[0] ##1 !cl_commit_w[0]
                                   |-> cl_pend_q[0] ##1 !cl_pend_q[0])
    else $error("window commit bit did not self-clear");
  AST_DEC_PULSE: assert property (decim_commit_o |-> $past(cl_commit_w[2]))
    else $error("decimation commit without write");
  AST_TIM_HOLD: assert property (!cl_pend_q[3] |=> $stable(wk_sync_q) && $stable(wk_active_video_flag_q))
    else $error("timing mode changed without commit");
  AST_FREE_RUN: assert property (##1 sync_free_run_o == (wk_sync_q == VWC_SYNC_SCAN))
    else $error("free-run output disagrees with mode");
  AST_WIN_ENABLE: assert property (!wk_enable_q |=> !vbi_window_o)
    else $error("window active while disabled");
  AST_SUPPRESS: assert property (in_win_w && wk_suppress_q |=> !active_video_flag_o)
    else $error("active video not suppressed in window");
  AST_RANGE: assert property (range_fmt_o |-> $past(in_win_w))
    else $error("range format outside window");
  AST_PAYLOAD: assert property (wk_slice_len_q == 12'h000 |=> payload_len_o == 12'h040)
    else $error("zero payload length not mapped to 64");
  AST_RAW_LIMIT: assert property (raw_pass_o |-> $past(raw_cnt_q) < 11'h474)
    else $error("raw samples beyond 1140");
  AST_EVEN_WIN: assert property (wk_enable_q && !field_odd_i && frame_line_i == wk_first_even_q
                                 |=> vbi_window_o)
    else $error("even window missed at frame line count");
  AST_STATE_RO: assert property (wr_w |-> !vwc_hit(paddr_i, `VWC_IDX_STATE_RB))
    else $error("state word written");

endmodule : vwc_window_latch
`default_nettype wire

// ---- sim/vwc_host_model.sv ----
// Host model that programs the VBI window bank over APB
`timescale 1ns/1ps
`default_nettype none

module vwc_host_model (
  // Clock
  input  wire logic        mclk_i,
  // APB master side
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic      [11:0] paddr_o,
  output logic      [31:0] pwdata_o,
  input  wire logic [31:0] prdata_i,
  input  wire logic        pready_i,
  input  wire logic        pslverr_i
);

  // --------------------------------------------------------------------------
  // Idle bus at time zero
  // --------------------------------------------------------------------------
  initial begin
    psel_o    = 1'b0;
    penable_o = 1'b0;
    pwrite_o  = 1'b0;
    paddr_o   = 12'h000;
    pwdata_o  = 32'h0000_0000;
  end

  // One transfer; waits as long as the slave takes, only the bench watchdog ends a hang
  task automatic xfer(input logic wr, input logic [9:0] idx, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge mclk_i);
    psel_o    <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o  <= wr;
    paddr_o   <= {idx, 2'b00};
    pwdata_o  <= (idx == 10'h140) ? (d & 32'hFFFF_FDE7) : d;
    @(posedge mclk_i);
    penable_o <= 1'b1;
    @(posedge mclk_i);
    while (pready_i !== 1'b1) begin
      @(posedge mclk_i);
    end
    rd  = prdata_i;
    err = pslverr_i;
    psel_o    <= 1'b0;
    penable_o <= 1'b0;
  endtask : xfer

endmodule : vwc_host_model

`default_nettype wire

// ---- sim/tb.sv ----
// Self-checking bench for the VBI window and control latch bank
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic        mclk_i, rstn_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, err;
  logic [11:0] paddr_i, frame_line_i, payload_len_o;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic        field_odd_i, line_start_i, sample_stb_i, slice_byte_stb_i, window_act_i;
  logic        field_act_i, range_fmt_i, vbi_window_o, active_video_flag_o, raw_pass_o;
  logic        sliced_pass_o, slice_pkg_end_o, range_fmt_o, sync_free_run_o;
  logic        active_video_flag_programmed_o, window1_commit_o, window2_commit_o, decim_commit_o;
  logic [11:0] fe = 12'h110, le = 12'h11B, fo = 12'h00A, lo = 12'h015;
  logic [11:0] ev [5] = '{12'h10F, 12'h110, 12'h11B, 12'h11C, 12'h00F};
  logic [11:0] od [5] = '{12'h009, 12'h00A, 12'h015, 12'h016, 12'h110};
  logic        en = 1'b0, sl = 1'b0, supp = 1'b0, vprog = 1'b0;
  logic [1:0]  sm = 2'h0;
  int          n_fail = 0, tests_run = 0, seed = 87046, c_raw = 0, c_sl = 0, c_end = 0;
  int          c_cm [3] = '{0, 0, 0};
  int          cb [3] = '{5, 6, 10};

  vwc_window_latch dut_u (
    .mclk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
    .pready_o, .pslverr_o, .frame_line_i, .field_odd_i, .line_start_i, .sample_stb_i,
    .slice_byte_stb_i, .window_act_i, .field_act_i, .range_fmt_i, .vbi_window_o,
    .active_video_flag_o, .raw_pass_o, .sliced_pass_o, .slice_pkg_end_o, .range_fmt_o,
    .payload_len_o, .sync_free_run_o, .active_video_flag_programmed_o, .window1_commit_o,
    .window2_commit_o, .decim_commit_o
  );

  vwc_host_model host_u (
    .mclk_i, .psel_o(psel_i), .penable_o(penable_i), .pwrite_o(pwrite_i),
    .paddr_o(paddr_i), .pwdata_o(pwdata_i), .prdata_i(prdata_o), .pready_i(pready_o),
    .pslverr_i(pslverr_o)
  );

  // --------------------------------------------------------------------------
  // Clock, pulse counters and watchdog
  // --------------------------------------------------------------------------
  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end

  // Count output pulses, one per high cycle
  always @(posedge mclk_i) begin
    c_raw += 32'(raw_pass_o === 1'b1);
    c_sl  += 32'(sliced_pass_o === 1'b1);
    c_end += 32'(slice_pkg_end_o === 1'b1);
    c_cm[0] += 32'(window1_commit_o === 1'b1);
    c_cm[1] += 32'(window2_commit_o === 1'b1);
    c_cm[2] += 32'(decim_commit_o === 1'b1);
  end

  // Cut a hang short
  initial begin
    repeat (20000) @(posedge mclk_i);
    n_fail++;
    results();
  end

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic in_win(input logic [11:0] ln, input logic odd);
    return en & (odd ? (ln >= fo && ln <= lo) : (ln >= fe && ln <= le));
  endfunction : in_win

  function automatic logic [31:0] st_exp();
    return {24'h000000, supp, sl, en, 2'b00, vprog, sm};
  endfunction : st_exp

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [9:0] idx, input logic [11:0] d);
    host_u.xfer(1'b1, idx, {20'h00000, d}, rd, err);
    repeat (3) @(posedge mclk_i);
    #1;
  endtask : wr

  task automatic rdr(input logic [9:0] idx);
    host_u.xfer(1'b0, idx, 32'h0000_0000, rd, err);
  endtask : rdr

  // Present one line with random activity and range inputs and check the window outputs
  task automatic vid(input logic [11:0] ln, input logic odd);
    logic w, a;
    @(posedge mclk_i);
    frame_line_i <= ln;
    field_odd_i  <= odd;
    {window_act_i, field_act_i, range_fmt_i} <= 3'($random(seed));
    @(posedge mclk_i);
    #1;
    w = in_win(ln, odd);
    check("window", 32'(vbi_window_o), 32'(w));
    a = (vprog ? field_act_i : window_act_i) & ~(w & supp);
    check("active", 32'(active_video_flag_o), 32'(a));
    check("range", 32'(range_fmt_o), 32'(range_fmt_i & w));
  endtask : vid

  task automatic line_go(input logic [11:0] ln);
    @(posedge mclk_i);
    frame_line_i <= ln;
    field_odd_i  <= 1'b1;
    line_start_i <= 1'b1;
    @(posedge mclk_i);
    line_start_i <= 1'b0;
  endtask : line_go

  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    {frame_line_i, field_odd_i, line_start_i, sample_stb_i} = 15'h0000;
    {slice_byte_stb_i, window_act_i, field_act_i, range_fmt_i} = 4'h0;
    rstn_i = 1'b0;
    repeat (4) @(posedge mclk_i);
    rstn_i <= 1'b1;
    #1;
    check("payload", 32'(payload_len_o), 32'h40);
    rdr(10'h141);
    check("state", rd, st_exp());
    vid(12'h110, 1'b0);
    $display("test reset done");
    en = 1'b1;
    wr(10'h138, 12'h801);
    for (int i = 0; i < 5; i++) begin
      vid(ev[i], 1'b0);
      vid(od[i], 1'b1);
    end
    $display("test bounds done");
    wr(10'h134, 12'h12C);
    wr(10'h135, 12'h131);
    vid(12'h12C, 1'b0);
    fe = 12'h12C;
    le = 12'h131;
    wr(10'h138, 12'h801);
    vid(12'h12C, 1'b0);
    vid(12'h12B, 1'b0);
    repeat (6) begin
      fo = 12'($random(seed)) & 12'h0FF;
      lo = fo + (12'($random(seed)) & 12'h01F);
      wr(10'h136, fo);
      wr(10'h137, lo);
      wr(10'h138, 12'h801);
      vid(fo - 12'h001, 1'b1);
      vid(fo, 1'b1);
      vid(lo, 1'b1);
      vid(lo + 12'h001, 1'b1);
    end
    $display("test random windows done");
    wr(10'h139, 12'h005);
    check("payload", 32'(payload_len_o), 32'h40);
    sl = 1'b1;
    wr(10'h138, 12'h803);
    check("payload", 32'(payload_len_o), 32'h5);
    line_go(fo);
    c_sl = 0;
    c_end = 0;
    slice_byte_stb_i <= 1'b1;
    repeat (10) @(posedge mclk_i);
    slice_byte_stb_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    check("sliced", 32'(c_sl), 32'hA);
    check("packages", 32'(c_end), 32'h2);
    sl = 1'b0;
    wr(10'h138, 12'h801);
    line_go(fo);
    c_raw = 0;
    sample_stb_i <= 1'b1;
    repeat (1145) @(posedge mclk_i);
    sample_stb_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    check("raw", 32'(c_raw), 32'h474);
    wr(10'h139, 12'h000);
    wr(10'h138, 12'h801);
    check("payload", 32'(payload_len_o), 32'h40);
    $display("test data modes done");
    supp = 1'b1;
    wr(10'h138, 12'h805);
    vid(fo, 1'b1);
    vid(lo + 12'h001, 1'b1);
    vprog = 1'b1;
    wr(10'h140, 12'h804);
    check("active_video_flag mode", 32'(active_video_flag_programmed_o), 32'h1);
    vid(fo, 1'b1);
    vid(lo + 12'h001, 1'b1);
    vprog = 1'b0;
    sm = 2'h2;
    wr(10'h140, 12'h802);
    check("free run", 32'(sync_free_run_o), 32'h1);
    rdr(10'h141);
    check("state", rd, st_exp());
    for (int i = 0; i < 3; i++) begin
      c_cm[i] = 0;
      wr(10'h140, 12'h001 << cb[i]);
      check("commit pulses", 32'(c_cm[i]), 32'h1);
      rdr(10'h140);
      check("commit bit", 32'(rd[cb[i]]), 32'h0);
      check("free run", 32'(sync_free_run_o), 32'h1);
    end
    sm = 2'h0;
    wr(10'h140, 12'h800);
    check("free run", 32'(sync_free_run_o), 32'h0);
    $display("test control word done");
    rdr(10'h100);
    check("unmapped error", 32'(err), 32'h1);
    host_u.xfer(1'b1, 10'h141, 32'h0000_0FFF, rd, err);
    check("state write error", 32'(err), 32'h1);
    rdr(10'h141);
    check("state", rd, st_exp());
    $display("test refusals done");
    results();
  end

endmodule : tb

`default_nettype wire
